// >>> design/srx_baud.sv
/*
 * Baud generator: one sample tick at sixteen times the bit rate.
 * Assumes the rate fields come straight from the rate register.
 */
`timescale 1ns/100ps
`include "srx_params.svh"

module srx_baud
  import srx_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] prescale_sel,
  input  wire logic [2:0] rate_divisor_sel,
  output logic            sample_tick
);

  logic [12:0] cnt_q;
  logic [12:0] period;

  // ----------------------------------------------------------------------
  // divisor arithmetic
  // ----------------------------------------------------------------------
  function automatic logic [3:0] prescale_div(input logic [1:0] code);
    case (code)
      2'b00:   prescale_div = 4'h1;
      2'b01:   prescale_div = 4'h3;
      2'b10:   prescale_div = 4'h4;
      default: prescale_div = 4'hd;
    endcase
  endfunction

  // bit rate = clk / (64 * pd * bd); ticks come 16 times as often
  assign period = 13'((`SRX_RATE_DIV / `SRX_OVERSAMPLE)
                  * prescale_div(prescale_sel)
                  * (1 << rate_divisor_sel)); // RQ18 RQ19 RQ20

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q       <= 13'h0000;
      sample_tick <= 1'b0;
    end else if (cnt_q >= period - 13'h0001) begin
      cnt_q       <= 13'h0000;
      sample_tick <= 1'b1;
    end else begin
      cnt_q       <= cnt_q + 13'h0001;
      sample_tick <= 1'b0;
    end
  end

endmodule

// >>> design/srx_params.svh
/*
 * Register indices, field positions, reset values and timing counts of
 * the serial receive status and baud block.
 * Assumes AXI4-Lite byte addresses: each index times four is the address.
 */
`ifndef SRX_PARAMS_SVH
`define SRX_PARAMS_SVH

// ----------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define SRX_IDX_STATUS_ONE  10'h03b
`define SRX_IDX_STATUS_TWO  10'h03c
`define SRX_IDX_DATA        10'h03d
`define SRX_IDX_RATE        10'h03e
`define SRX_IDX_CTRL_THREE  10'h040
`define SRX_IDX_CONFIG      10'h041

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SRX_S1_FULL         5
`define SRX_S1_OVR          3
`define SRX_S1_FE           1
`define SRX_S1_PE           0
`define SRX_S2_BRK          1
`define SRX_S2_RPF          0
`define SRX_C3_NINTH        7
`define SRX_C3_OVR_IE       3
`define SRX_C3_FE_IE        1
`define SRX_C3_PE_IE        0
`define SRX_RATE_PS_HI      5
`define SRX_RATE_PS_LO      4
`define SRX_RATE_DV_HI      2
`define SRX_RATE_DV_LO      0
`define SRX_CF_ENABLE       0
`define SRX_CF_NINE         1
`define SRX_CF_PAR_EN       2
`define SRX_CF_PAR_ODD      3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SRX_RST_STATUS_TWO  8'h00
`define SRX_RST_RATE        8'h00
`define SRX_RST_CTRL_THREE  8'h00
`define SRX_RST_CONFIG      8'h00

// ----------------------------------------------------------------------
// timing counts and AXI response codes
// ----------------------------------------------------------------------
`define SRX_RATE_DIV        64
`define SRX_OVERSAMPLE      16
`define SRX_SLOT_FIRST      5'h01
`define SRX_SLOT_MID        5'h08
`define SRX_SLOT_LAST       5'h10
`define SRX_IDLE_TICKS      8'ha0
`define SRX_RESP_OKAY       2'b00
`define SRX_RESP_SLVERR     2'b10

`endif

// >>> design/srx_pkg.sv
/*
 * Types of the serial receive status and baud block.
 * Assumes srx_params.svh supplies the numeric constants.
 */
package srx_pkg;

  typedef enum logic [2:0] {
    SRX_IDLE      = 3'b000,
    SRX_START     = 3'b001,
    SRX_DATA      = 3'b010,
    SRX_STOP      = 3'b011,
    SRX_WAIT_HIGH = 3'b100
  } srx_state_t;

  typedef logic [7:0] srx_byte_t;

endpackage

// >>> design/srx_rx.sv
/*
 * Receive engine: start search, data, parity and stop sampling.
 * Assumes one sample_tick per sixteenth of a bit and a synchronous line.
 */
`timescale 1ns/100ps
`include "srx_params.svh"

module srx_rx
  import srx_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       sample_tick,
  input  wire logic       rx_line,
  input  wire logic       rx_enable,
  input  wire logic       nine_bit,
  input  wire logic       parity_en,
  input  wire logic       parity_odd,
  output logic            char_done,
  output logic [7:0]      char_data,
  output logic            char_ninth,
  output logic            char_frame_err,
  output logic            char_parity_err,
  output logic            char_break,
  output logic            rpf_set,
  output logic            rpf_clr
);

  srx_state_t  state_q;
  logic [4:0]  slot_q;
  logic [3:0]  bits_q;
  logic [8:0]  sh_q;
  logic [7:0]  idle_q;
  logic        last_slot;
  logic        mid_slot;
  logic [3:0]  nbits;
  logic [8:0]  word;
  logic        xsum;

  assign last_slot = sample_tick && (slot_q == `SRX_SLOT_LAST);
  assign mid_slot  = sample_tick && (slot_q == `SRX_SLOT_MID);
  assign nbits     = nine_bit ? 4'h9 : 4'h8;
  assign word      = nine_bit ? sh_q : {sh_q[8], sh_q[8:1]};
  assign xsum      = nine_bit ? ^sh_q : ^sh_q[8:1];

  // ----------------------------------------------------------------------
  // frame sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q         <= SRX_IDLE;
      slot_q          <= 5'h00;
      bits_q          <= 4'h0;
      sh_q            <= 9'h000;
      char_done       <= 1'b0;
      char_data       <= 8'h00;
      char_ninth      <= 1'b0;
      char_frame_err  <= 1'b0;
      char_parity_err <= 1'b0;
      char_break      <= 1'b0;
      rpf_set         <= 1'b0;
    end else begin
      char_done <= 1'b0;
      rpf_set   <= 1'b0;
      if (sample_tick) begin
        slot_q <= (slot_q == `SRX_SLOT_LAST) ? `SRX_SLOT_FIRST
                                            : slot_q + 5'h01; // RQ22
      end
      case (state_q)
        SRX_IDLE: begin
          if (sample_tick && rx_enable && !rx_line) begin
            state_q <= SRX_START;
            slot_q  <= `SRX_SLOT_FIRST + 5'h01;
            rpf_set <= 1'b1; // RQ13
          end
        end
        SRX_START: begin
          if (mid_slot && rx_line) begin
            state_q <= SRX_IDLE; // RQ14
          end else if (last_slot) begin
            state_q <= SRX_DATA;
            bits_q  <= 4'h0;
          end
        end
        SRX_DATA: begin
          if (mid_slot) begin
            sh_q   <= {rx_line, sh_q[8:1]};
            bits_q <= bits_q + 4'h1;
          end else if (last_slot && bits_q == nbits) begin
            state_q <= SRX_STOP;
          end
        end
        SRX_STOP: begin
          if (mid_slot) begin
            char_done       <= 1'b1;
            char_data       <= word[7:0];
            char_ninth      <= word[8];
            char_frame_err  <= !rx_line; // RQ1
            char_parity_err <= parity_en && (xsum != parity_odd); // RQ4
            char_break      <= !rx_line && (word == 9'h000); // RQ8
            // a low stop means the line must rise before a new search
            state_q <= rx_line ? SRX_IDLE : SRX_WAIT_HIGH; // RQ12
          end
        end
        SRX_WAIT_HIGH: begin
          if (sample_tick && rx_line) begin
            state_q <= SRX_IDLE; // RQ12
          end
        end
        default: state_q <= SRX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // false start and idle character detection
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_q  <= 8'h00;
      rpf_clr <= 1'b0;
    end else begin
      rpf_clr <= (state_q == SRX_START) && mid_slot && rx_line; // RQ14
      if (state_q != SRX_IDLE || !rx_line) begin
        idle_q <= 8'h00;
      end else if (sample_tick && idle_q != `SRX_IDLE_TICKS) begin
        idle_q <= idle_q + 8'h01;
        if (idle_q == `SRX_IDLE_TICKS - 8'h01) begin
          rpf_clr <= 1'b1; // RQ14
        end
      end
    end
  end

endmodule

// >>> design/srx_top.sv
/*
 * Serial receive status, data buffer and baud rate block, AXI4-Lite slave.
 * Assumes the receive pin is synchronous to aclk and a single-word master.
 */
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "srx_params.svh"

//
// Contract
// RQ1: low stop bit sets framing error
// RQ2: framing error with enable raises error irq
// RQ3: status-one read then data read clears framing
// RQ4: parity check failure sets parity error
// RQ5: parity error with enable raises irq
// RQ6: status-one read then data read clears parity
// RQ7: status two: break bit1, active bit0
// RQ8: break sets break, framing, full flags
// RQ9: break in nine-bit mode zeroes ninth bit
// RQ10: break flag never raises an interrupt
// RQ11: status-two read then data read clears break
// RQ12: new break needs line high first
// RQ13: low at first slot sets active
// RQ14: false start or idle clears active
// RQ15: data address: read received, write transmit
// RQ16: reset leaves data buffer untouched
// RQ17: one rate setting for both directions
// RQ18: prescaler codes give 1,3,4,13
// RQ19: rate divisor is two to code
// RQ20: bit rate is clock/(64*pd*bd)
// RQ21: overrun keeps old char, flags overrun
// RQ22: sixteen samples per bit from slot one
module srx_top
  import srx_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        receive_line_pin,
  output logic [7:0]       tx_data,
  output logic             tx_data_load,
  output logic [7:0]       rate_setting,
  output logic             serial_err_irq
);

  // write channel capture
  logic [9:0]  aw_idx_q;
  logic        aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        w_have_q;
  logic        wr_fire;
  logic        wr_lane0;
  // read channel
  logic        rd_fire;
  logic [9:0]  ar_idx;
  logic [7:0]  rd_val;
  logic        rd_hit;
  logic        rd_status1;
  logic        rd_status2;
  logic        rd_data;
  // registers
  srx_byte_t   rate_q;
  srx_byte_t   ctrl3_q;
  srx_byte_t   config_q;
  srx_byte_t   rx_buf_q;
  logic        ninth_rx_bit_q;
  // flags and clear arming
  logic        framing_error_flag_q;
  logic        parity_error_flag_q;
  logic        overrun_flag_q;
  logic        rx_full_flag_q;
  logic        break_flag_q;
  logic        receive_active_flag_q;
  logic        arm_fe_q;
  logic        arm_pe_q;
  logic        arm_ovr_q;
  logic        arm_full_q;
  logic        arm_brk_q;
  // receive engine
  logic        sample_tick;
  logic        char_done;
  logic [7:0]  char_data;
  logic        char_ninth;
  logic        char_frame_err;
  logic        char_parity_err;
  logic        char_break;
  logic        rpf_set;
  logic        rpf_clr;
  logic        rx_event;
  logic        overrun;
  logic        load;
  logic        clr_seq;

  // ----------------------------------------------------------------------
  // baud generator and receive engine
  // ----------------------------------------------------------------------
  srx_baud u_baud (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .prescale_sel     (rate_q[`SRX_RATE_PS_HI:`SRX_RATE_PS_LO]),
    .rate_divisor_sel (rate_q[`SRX_RATE_DV_HI:`SRX_RATE_DV_LO]),
    .sample_tick      (sample_tick)
  );

  srx_rx u_rx (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .sample_tick     (sample_tick),
    .rx_line         (receive_line_pin),
    .rx_enable       (config_q[`SRX_CF_ENABLE]),
    .nine_bit        (config_q[`SRX_CF_NINE]),
    .parity_en       (config_q[`SRX_CF_PAR_EN]),
    .parity_odd      (config_q[`SRX_CF_PAR_ODD]),
    .char_done       (char_done),
    .char_data       (char_data),
    .char_ninth      (char_ninth),
    .char_frame_err  (char_frame_err),
    .char_parity_err (char_parity_err),
    .char_break      (char_break),
    .rpf_set         (rpf_set),
    .rpf_clr         (rpf_clr)
  );

  // transmitter shares this rate setting
  assign rate_setting = rate_q; // RQ17

  // ----------------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------------
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;
  assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_lane0      = wr_fire && w_strb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_idx_q  <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_idx_q  <= s_axi_awaddr[11:2];
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SRX_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      // status registers are mapped; writes to them are ignored
      s_axi_bresp  <= (aw_idx_q == `SRX_IDX_STATUS_ONE ||
                       aw_idx_q == `SRX_IDX_STATUS_TWO ||
                       aw_idx_q == `SRX_IDX_DATA       ||
                       aw_idx_q == `SRX_IDX_RATE       ||
                       aw_idx_q == `SRX_IDX_CTRL_THREE ||
                       aw_idx_q == `SRX_IDX_CONFIG) ? `SRX_RESP_OKAY
                                                    : `SRX_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_q   <= `SRX_RST_RATE; // RQ18 RQ19
      ctrl3_q  <= `SRX_RST_CTRL_THREE;
      config_q <= `SRX_RST_CONFIG;
    end else if (wr_lane0) begin
      if (aw_idx_q == `SRX_IDX_RATE) begin
        rate_q <= {2'b00, w_data_q[5:4], 1'b0, w_data_q[2:0]};
      end
      if (aw_idx_q == `SRX_IDX_CTRL_THREE) begin
        ctrl3_q <= {4'h0, w_data_q[3], 1'b0, w_data_q[1:0]};
      end
      if (aw_idx_q == `SRX_IDX_CONFIG) begin
        config_q <= {4'h0, w_data_q[3:0]};
      end
    end
  end

  // transmit byte and its load strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_data_load <= 1'b0;
      tx_data      <= 8'h00;
    end else begin
      tx_data_load <= wr_lane0 && (aw_idx_q == `SRX_IDX_DATA); // RQ15
      if (wr_lane0 && aw_idx_q == `SRX_IDX_DATA) begin
        tx_data <= w_data_q[7:0]; // RQ15
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign ar_idx        = s_axi_araddr[11:2];
  assign rd_status1    = rd_fire && (ar_idx == `SRX_IDX_STATUS_ONE);
  assign rd_status2    = rd_fire && (ar_idx == `SRX_IDX_STATUS_TWO);
  assign rd_data       = rd_fire && (ar_idx == `SRX_IDX_DATA);

  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    case (ar_idx)
      `SRX_IDX_STATUS_ONE: begin
        rd_val[`SRX_S1_FULL] = rx_full_flag_q;
        rd_val[`SRX_S1_OVR]  = overrun_flag_q;
        rd_val[`SRX_S1_FE]   = framing_error_flag_q;
        rd_val[`SRX_S1_PE]   = parity_error_flag_q;
      end
      `SRX_IDX_STATUS_TWO: begin
        // upper six bits stay zero
        rd_val[`SRX_S2_BRK] = break_flag_q; // RQ7
        rd_val[`SRX_S2_RPF] = receive_active_flag_q; // RQ7
      end
      `SRX_IDX_DATA:       rd_val = rx_buf_q; // RQ15
      `SRX_IDX_RATE:       rd_val = rate_q;
      `SRX_IDX_CTRL_THREE: begin
        rd_val = ctrl3_q;
        rd_val[`SRX_C3_NINTH] = ninth_rx_bit_q;
      end
      `SRX_IDX_CONFIG:     rd_val = config_q;
      default:             rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SRX_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_val};
      s_axi_rresp  <= rd_hit ? `SRX_RESP_OKAY : `SRX_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // character arrival
  // ----------------------------------------------------------------------
  // a status read arms only the flags it saw; the data read fires them
  assign clr_seq  = rd_data;
  assign rx_event = char_done && config_q[`SRX_CF_ENABLE];
  assign overrun  = rx_event && rx_full_flag_q
                    && !(clr_seq && arm_full_q); // RQ21
  assign load     = rx_event && !overrun;

  // no reset: buffer keeps its byte through reset
  always_ff @(posedge aclk) begin
    if (load) begin
      rx_buf_q <= char_data; // RQ15 RQ16 RQ21
      ninth_rx_bit_q <= (config_q[`SRX_CF_NINE] && char_break) ? 1'b0
                                                           : char_ninth; // RQ9
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_fe_q   <= 1'b0;
      arm_pe_q   <= 1'b0;
      arm_ovr_q  <= 1'b0;
      arm_full_q <= 1'b0;
      arm_brk_q  <= 1'b0;
    end else begin
      if (rd_status1) begin
        arm_fe_q   <= framing_error_flag_q; // RQ3
        arm_pe_q   <= parity_error_flag_q; // RQ6
        arm_ovr_q  <= overrun_flag_q;
        arm_full_q <= rx_full_flag_q;
      end else if (clr_seq) begin
        arm_fe_q   <= 1'b0;
        arm_pe_q   <= 1'b0;
        arm_ovr_q  <= 1'b0;
        arm_full_q <= 1'b0;
      end
      if (rd_status2) begin
        arm_brk_q <= break_flag_q; // RQ11
      end else if (clr_seq) begin
        arm_brk_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // status flags: a set in the clearing cycle wins
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      framing_error_flag_q <= 1'b0;
    end else if (load && (char_frame_err || char_break)) begin
      framing_error_flag_q <= 1'b1; // RQ1 RQ8
    end else if (clr_seq && arm_fe_q) begin
      framing_error_flag_q <= 1'b0; // RQ3
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      parity_error_flag_q <= 1'b0;
    end else if (load && char_parity_err) begin
      parity_error_flag_q <= 1'b1; // RQ4
    end else if (clr_seq && arm_pe_q) begin
      parity_error_flag_q <= 1'b0; // RQ6
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_flag_q <= 1'b0;
    end else if (overrun) begin
      overrun_flag_q <= 1'b1; // RQ21
    end else if (clr_seq && arm_ovr_q) begin
      overrun_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_full_flag_q <= 1'b0;
    end else if (load) begin
      rx_full_flag_q <= 1'b1; // RQ8
    end else if (clr_seq && arm_full_q) begin
      rx_full_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      break_flag_q <= 1'b0; // RQ11
    end else if (load && char_break) begin
      break_flag_q <= 1'b1; // RQ8
    end else if (clr_seq && arm_brk_q) begin
      break_flag_q <= 1'b0; // RQ11
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      receive_active_flag_q <= 1'b0;
    end else if (rpf_set) begin
      receive_active_flag_q <= 1'b1; // RQ13
    end else if (rpf_clr) begin
      receive_active_flag_q <= 1'b0; // RQ14
    end
  end

  // ----------------------------------------------------------------------
  // error interrupt request
  // ----------------------------------------------------------------------
  // break and receive-active are poll-only and feed nothing here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_err_irq <= 1'b0;
    end else begin
      serial_err_irq <=
        (framing_error_flag_q && ctrl3_q[`SRX_C3_FE_IE]) || // RQ2
        (parity_error_flag_q  && ctrl3_q[`SRX_C3_PE_IE]) || // RQ5
        (overrun_flag_q       && ctrl3_q[`SRX_C3_OVR_IE]); // RQ10
    end
  end

endmodule

// >>> test/srx_chk.sv
/* Port checker for srx_top, bound to every instance below.
   Assumes one clock, aclk, and the synchronous low reset aresetn. */
`timescale 1ns/100ps
module srx_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_data_load,
  input wire logic [7:0]  rate_setting,
  input wire logic        serial_err_irq
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  rd_lat_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  rd_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  rd_upper_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  tx_pulse_a: assert property (
    tx_data_load |-> s_axi_bvalid ##1 !tx_data_load) else $error("load pulse");
  tx_only_a: assert property (
    $changed(tx_data) |-> tx_data_load) else $error("tx data moved");
  rate_wr_a: assert property (
    $changed(rate_setting) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("rate moved without write");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid drop");
  rst_clr_a: assert property (disable iff (1'b0)
    !aresetn |=> !s_axi_rvalid && !s_axi_bvalid && !serial_err_irq)
    else $error("reset left state");
  rd_c: cover property (s_axi_rvalid && s_axi_rready);
  ld_c: cover property (tx_data_load);
  irq_c: cover property ($rose(serial_err_irq));
endmodule
bind srx_top srx_chk u_chk (.*);

// >>> test/srx_line_model.sv
/* Remote serial transmitter driving the receive pin.
   Assumes the rate register at zero: one bit per 64 clocks. */
`timescale 1ns/100ps
module srx_line_model (
  input wire logic aclk,
  output logic     line
);
  initial line = 1'b1;
  // line idles high; long gap lets the idle detector clear activity
  task automatic send(input logic [7:0] d, input logic stp);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= f[i];
      repeat (64) @(posedge aclk);
    end
    line <= 1'b1;
    repeat (700) @(posedge aclk);
  endtask
endmodule

// >>> test/tb_srx_top.sv
/* Self-checking bench for srx_top over AXI4-Lite and the receive pin.
   Assumes srx_line_model sends frames at the fastest rate. */
`timescale 1ns/100ps
module tb_srx_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        tx_data_load, serial_err_irq, receive_line_pin;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  tx_data, rate_setting;
  int          fails = 0;
  int          tests_run = 0;
  always #2 aclk = ~aclk;
  srx_top dut (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hf));
  srx_line_model u_ln (.aclk(aclk), .line(receive_line_pin));
  task automatic conclude();
    $display("tests %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // ready and answers sampled at the rising edge that takes them
  task automatic acc(input logic we, input logic [11:0] a,
                     input logic [7:0] d, output logic [33:0] q);
    int   n;
    logic ha, hw, hd;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= we;
    s_axi_wvalid <= we;
    s_axi_bready <= we;
    s_axi_arvalid <= !we;
    s_axi_rready <= !we;
    n = 0;
    do begin
      @(posedge aclk);
      ha = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
      hw = s_axi_wvalid && s_axi_wready;
      hd = we ? s_axi_bvalid : s_axi_rvalid;
      q = we ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
      n++;
      if (ha) s_axi_awvalid <= 1'b0;
      if (ha) s_axi_arvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end while (!hd && n < 40);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (!hd) begin
      fails++;
      conclude();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [33:0] q;
    acc(1'b1, a, d, q);
    chk(q, 34'h0);
  endtask
  task automatic rc(input logic [11:0] a, input logic [33:0] e);
    logic [33:0] q;
    acc(1'b0, a, 8'h0, q);
    chk(q, e);
  endtask
  task automatic t_regs();
    rc(12'h0f0, 34'h0);
    rc(12'h0f8, 34'h0);
    rc(12'h0fc, 34'h200000000);
    wr(12'h0f0, 8'hff);
    rc(12'h0f0, 34'h0);
    wr(12'h0f8, 8'h37);
    rc(12'h0f8, 34'h37);
    chk({26'h0, rate_setting}, 34'h37);
    wr(12'h0f8, 8'h00);
    wr(12'h0f4, 8'h5a);
    @(negedge aclk);
    chk({26'h0, tx_data}, 34'h5a);
    $display("regs done");
  endtask
  task automatic t_ovr();
    wr(12'h104, 8'h01);
    u_ln.send(8'ha5, 1'b1);
    u_ln.send(8'h3c, 1'b1);
    rc(12'h0ec, 34'h28);
    rc(12'h0f4, 34'ha5);
    rc(12'h0ec, 34'h0);
    $display("overrun done");
  endtask
  task automatic t_fe();
    wr(12'h100, 8'h02);
    u_ln.send(8'h3c, 1'b0);
    chk({33'h0, serial_err_irq}, 34'h1);
    rc(12'h0ec, 34'h22);
    rc(12'h0f4, 34'h3c);
    rc(12'h0ec, 34'h0);
    @(negedge aclk);
    chk({33'h0, serial_err_irq}, 34'h0);
    $display("framing done");
  endtask
  task automatic t_pe();
    wr(12'h104, 8'h05);
    wr(12'h100, 8'h01);
    u_ln.send(8'h01, 1'b1);
    chk({33'h0, serial_err_irq}, 34'h1);
    rc(12'h0ec, 34'h21);
    rc(12'h0f4, 34'h01);
    rc(12'h0ec, 34'h0);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(12'h0f4, 34'h01);
    $display("parity done");
  endtask
  task automatic t_brk();
    wr(12'h104, 8'h01);
    u_ln.send(8'h00, 1'b0);
    chk({33'h0, serial_err_irq}, 34'h0);
    rc(12'h0f0, 34'h02);
    rc(12'h0ec, 34'h22);
    rc(12'h0f4, 34'h00);
    rc(12'h0f0, 34'h0);
    $display("break done");
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_ovr();
    t_fe();
    t_pe();
    t_brk();
    conclude();
  end
endmodule
